// ===== inc/frl_defines.svh
// offsets, field positions, reset values and timing counts of the fault reaction block
`ifndef FRL_DEFINES_SVH
`define FRL_DEFINES_SVH
// clock and timing figures in picoseconds / nanoseconds as printed
`define FRL_CLK_PERIOD_PS 5000
`define FRL_TICK_PS 31250000
`define FRL_MS_PS 1000000000
`define FRL_CLEAR_TIME_NS 10000
// least time: rounded up to whole cycles
`define FRL_CLEAR_CYC ((`FRL_CLEAR_TIME_NS * 1000 + `FRL_CLK_PERIOD_PS - 1) / `FRL_CLK_PERIOD_PS)
`define FRL_TICKS_PER_MS (`FRL_MS_PS / `FRL_TICK_PS)
// cycles of observed low level before an edge counts as a real rising edge
`define FRL_PRIME_CYC 11'h008
// operation control field positions
`define FRL_OP_ON_HI 7
`define FRL_OP_ON_LO 6
`define FRL_OP_MRG_HI 5
`define FRL_OP_MRG_LO 4
// on/off source select field positions
`define FRL_SRC_HI 4
`define FRL_SRC_LO 2
// fault handling word: generic bits low, overvoltage reaction at top
`define FRL_FHC_OV_HI 15
`define FRL_FHC_OV_LO 14
// reset values
`define FRL_OP_RST 4'h8
`define FRL_SRC_RST 3'h5
`define FRL_TON_RST 9'h000
`endif

// ===== inc/frl_en_if.sv
// conditioned enable pin events passed from the pin stage to the top
interface frl_en_if;
   logic lvl;
   logic rise;
   logic fall;
   logic clr;
   modport prod (output lvl, rise, fall, clr);
   modport cons (input lvl, rise, fall, clr);
endinterface

// ===== inc/frl_pkg.sv
// types shared by the fault reaction and loop enable block
package frl_pkg;
   typedef enum logic [2:0] {
      FRL_CMD_OP = 3'h0,
      FRL_CMD_SRC = 3'h1,
      FRL_CMD_SWEN = 3'h2,
      FRL_CMD_TON = 3'h3,
      FRL_CMD_FHC = 3'h4,
      FRL_CMD_CLR_ALL = 3'h5,
      FRL_CMD_CLR_ONE = 3'h6,
      FRL_CMD_NONE = 3'h7
   } frl_cmd_e;
   // gray along idle -> force low -> safe
   typedef enum logic [1:0] {
      FRL_PD_IDLE = 2'h0,
      FRL_PD_FORCE = 2'h1,
      FRL_PD_SAFE = 2'h3
   } frl_pd_e;
   typedef enum logic [1:0] {
      FRL_OV_IGN = 2'h0,
      FRL_OV_LAT = 2'h1,
      FRL_OV_UNUSED = 2'h2,
      FRL_OV_PD = 2'h3
   } frl_ov_e;
endpackage

// ===== rtl/frl_en_pin.sv
// enable pin synchroniser, deglitch, edge detection and clear pulse
`include "frl_defines.svh"
module frl_en_pin (
   input wire logic clock, // system clock
   input wire logic rstn, // async reset, active low
   input wire logic pin, // raw enable pin
   frl_en_if.prod en // conditioned level and events
);
   logic s1_reg, s2_reg, s3_reg;
   logic lvl_reg, seen_low_reg, rise_reg, fall_reg, clr_reg;
   logic [10:0] low_cnt_reg;

   // ************************************
   // decode of the filtered pin
   // ************************************
   wire stable = s2_reg == s3_reg;
   wire go_up = stable && s3_reg && !lvl_reg;
   wire go_dn = stable && !s3_reg && lvl_reg;
   wire low_done = low_cnt_reg == 11'(`FRL_CLEAR_CYC);

   // two flops then a third sample for the glitch filter
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // low time measured on the filtered level, saturating
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         low_cnt_reg <= 11'h000;
         seen_low_reg <= 1'b0;
      end else begin
         if (lvl_reg)
            low_cnt_reg <= 11'h000;
         else if (!low_done)
            low_cnt_reg <= low_cnt_reg + 11'h001;
         // a pin high since reset never earns a rising edge
         if (low_cnt_reg >= `FRL_PRIME_CYC)
            seen_low_reg <= 1'b1;
      end
   end

   // edges and clear pulse, one cycle each
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lvl_reg <= 1'b0;
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
         clr_reg <= 1'b0;
      end else begin
         lvl_reg <= go_up | (lvl_reg & ~go_dn);
         rise_reg <= go_up && seen_low_reg;
         fall_reg <= go_dn;
         clr_reg <= go_up && seen_low_reg && low_done;
      end
   end

   assign en.lvl = lvl_reg;
   assign en.rise = rise_reg;
   assign en.fall = fall_reg;
   assign en.clr = clr_reg;

   a_clr_with_rise: assert property (@(posedge clock) disable iff (!rstn)
      en.clr |-> en.rise && en.lvl) else $error("clear without rising edge");
   // clear and level rise leave the same edge, so check in that very cycle
   a_short_low: assert property (@(posedge clock) disable iff (!rstn)
      $rose(lvl_reg) && !$past(low_done) |-> !en.clr) else $error("short low cleared");
endmodule

// ===== rtl/frl_top.sv
// fault reaction, clear handling and loop enable for a dual loop controller
// ************************************
// How it works
// - latched reaction outranks ignore reaction
// - latched fault: flag, redirect low, all PWM HiZ
// - exit safe state only after fault gone, then clear
// - enable low at least 10 us, then high, clears
// - clear-all clears every fault of the page, clear-one one fault
// - pin toggle clears own loop and common faults
// - bus clears use page; common faults ignore page
// - overvoltage setting 11: flag, redirect, loop PWM low
// - then safe state on low sense or negative current
// - fault override beats PWM generator at once
// - ignore fault only sets flag, cleared later
// - pin rise enables reference, fall disables it
// - pin level gates controller; no edge, no reference
// - operation bits 7:6 at 00 disable loop
// - operation bits 5:4 pick margin mode
// - source select 0xx keeps loop always enabled
// - 110 operation only; 101 pin or software
// - 111 operation and (pin or software)
// - unlisted encodings refused, other bits ignored
// - turn-on delay is count times 1 ms, zero off
// - delay timed by 31.25 us tick counter
// - single-bit reaction: 0 ignore, 1 latched, default latched
// - latched fault drives redirection low, sets flag
// ************************************
`include "frl_defines.svh"
module frl_top #(
   parameter int NF = 8, // generic fault inputs
   parameter logic [NF-1:0] L1_MASK = 'h3, // faults of loop 1
   parameter logic [NF-1:0] L2_MASK = 'hC, // faults of loop 2, rest common
   parameter logic [7:0] PH_L2 = 8'hF0, // phases assigned to loop 2
   parameter int TICK_CYC = `FRL_TICK_PS / `FRL_CLK_PERIOD_PS, // cycles per tick
   parameter int DET_DLY_CYC = 16 // low sense detect delay in cycles
) (
   input wire logic clock, // 200 MHz system clock
   input wire logic rstn, // async reset, active low
   input wire logic [1:0] loop_enable_pin, // loop 1 / loop 2 enable pins
   input wire logic [7:0] pwm_in, // PWM generator outputs
   input wire logic [NF-1:0] fault_det, // generic fault detections
   input wire logic [1:0] ov_det, // output overvoltage per loop
   input wire logic [1:0] vsense_low, // output_voltage_sense at or below 0.25 V
   input wire logic [1:0] neg_oc, // negative_slow_overcurrent_threshold reached
   input wire logic cmd_wr, // management command strobe
   input wire frl_pkg::frl_cmd_e cmd_code, // command selector
   input wire logic cmd_page, // selected loop, 0 or 1
   input wire logic [15:0] cmd_data, // command data
   output logic [7:0] pwm_out, // PWM pin value
   output logic [7:0] pwm_oe, // PWM pin driven, low is HiZ
   output logic [NF-1:0] fault_flag, // generic fault status flags
   output logic [1:0] ov_flag, // overvoltage status flags
   output logic [1:0] redir_n, // fault redirection per loop, low active
   output logic [1:0] loop_ctrl_en, // loop controller enable
   output logic [1:0] ref_en, // reference setpoint enable
   output logic [3:0] margin, // margin per loop, loop 2 high
   output logic invalid_cmd // refused command pulse
);
   import frl_pkg::*;

   localparam int DW = $clog2(DET_DLY_CYC + 1);

   // ************************************
   // elaboration checks
   // ************************************
   if (NF < 1 || NF > 14) begin : g_bad_nf
      $error("NF must be 1 to 14");
   end
   if (TICK_CYC < 2 || TICK_CYC > 8192) begin : g_bad_tick
      $error("TICK_CYC must be 2 to 8192");
   end
   if (DET_DLY_CYC < 1) begin : g_bad_det
      $error("DET_DLY_CYC must be positive");
   end

   logic [3:0] op_reg [2];
   logic [2:0] src_reg [2];
   logic [8:0] ton_reg [2];
   frl_ov_e ovcfg_reg [2];
   frl_pd_e pd_reg [2];
   frl_pd_e pd_next [2];
   logic [DW-1:0] det_cnt_reg [2];
   logic [1:0] swen_reg;
   logic [NF-1:0] react_reg, flag_reg, flag_next;
   logic [1:0] ov_flag_reg, ov_flag_next;
   logic [12:0] tick_cnt_reg;
   logic tick_reg, hiz_reg, invalid_reg;
   logic [7:0] pwm_out_reg, pwm_oe_reg;
   logic [1:0] redir_n_reg, ctrl_en_reg, ref_en_reg, ref_state_reg;
   logic [3:0] margin_reg;
   logic [1:0] pin_lvl, pin_rise, pin_fall, pin_clr, ton_on;
   logic [1:0] req, ov_hit, ov_lat, det_done, redir_next;

   // ************************************
   // helper functions
   // ************************************
   // loop request from the on/off source select
   function automatic logic src_en(input logic [2:0] src, input logic op_on,
                                   input logic pin_or_sw);
      logic r;
      r = 1'b0;
      case (src)
         3'h0, 3'h1, 3'h2, 3'h3: r = 1'b1;
         3'h6: r = op_on;
         3'h5: r = pin_or_sw;
         3'h7: r = op_on & pin_or_sw;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // modes in which the pin takes part
   function automatic logic pin_mode(input logic [2:0] src);
      return src == 3'h5 || src == 3'h7;
   endfunction

   // ************************************
   // pin stages and start delays
   // ************************************
   for (genvar l = 0; l < 2; l++) begin : g_loop
      frl_en_if en ();
      frl_en_pin u_pin (
         .clock(clock),
         .rstn(rstn),
         .pin(loop_enable_pin[l]),
         .en(en.prod)
      );
      assign pin_lvl[l] = en.lvl;
      assign pin_rise[l] = en.rise;
      assign pin_fall[l] = en.fall;
      assign pin_clr[l] = en.clr;
      frl_turn_on_delay_count u_ton (
         .clock(clock),
         .rstn(rstn),
         .tick(tick_reg),
         .req(req[l] & ~hiz_reg),
         .dly(ton_reg[l]),
         .on(ton_on[l])
      );
   end

   // ************************************
   // command decode
   // ************************************
   wire [1:0] op_on_f = cmd_data[`FRL_OP_ON_HI:`FRL_OP_ON_LO];
   wire [1:0] mrg_f = cmd_data[`FRL_OP_MRG_HI:`FRL_OP_MRG_LO];
   wire [2:0] src_f = cmd_data[`FRL_SRC_HI:`FRL_SRC_LO];
   wire op_ok = (op_on_f == 2'h0 || op_on_f == 2'h2) && mrg_f != 2'h3;
   wire src_ok = src_f != 3'h4;
   wire one_ok = {1'b0, cmd_data[3:0]} < 5'(NF + 2);
   wire is_op = cmd_wr && cmd_code == FRL_CMD_OP;
   wire is_src = cmd_wr && cmd_code == FRL_CMD_SRC;
   wire is_one = cmd_wr && cmd_code == FRL_CMD_CLR_ONE;
   wire clr_all = cmd_wr && cmd_code == FRL_CMD_CLR_ALL;
   wire clr_one = is_one && one_ok;
   wire bad_cmd = (is_op && !op_ok) || (is_src && !src_ok) || (is_one && !one_ok);

   // ************************************
   // fault flag clearing
   // ************************************
   wire [NF-1:0] common = ~(L1_MASK | L2_MASK);
   wire [NF-1:0] page_mask = (cmd_page ? L2_MASK : L1_MASK) | common;
   wire [NF-1:0] one_hot = NF'(1) << cmd_data[3:0];
   wire [NF-1:0] clr_gen = ({NF{pin_clr[0]}} & (L1_MASK | common))
                         | ({NF{pin_clr[1]}} & (L2_MASK | common))
                         | ({NF{clr_all}} & page_mask)
                         | ({NF{clr_one}} & one_hot & page_mask);
   // a clear only lands on a fault already gone; detection wins
   assign flag_next = fault_det | (flag_reg & ~clr_gen);

   // overvoltage flags are loop specific and sit after the generic ones
   always_comb begin
      for (int l = 0; l < 2; l++) begin
         ov_hit[l] = pin_clr[l] || (cmd_page == l[0] && (clr_all
                     || (clr_one && cmd_data[3:0] == 4'(NF + l))));
         ov_flag_next[l] = ov_det[l] | (ov_flag_reg[l] & ~ov_hit[l]);
         ov_lat[l] = ov_flag_reg[l] && ovcfg_reg[l] == FRL_OV_LAT;
         det_done[l] = det_cnt_reg[l] == DW'(DET_DLY_CYC) && vsense_low[l];
      end
   end

   // ************************************
   // active pull-down sequence
   // ************************************
   always_comb begin
      for (int l = 0; l < 2; l++) begin
         pd_next[l] = pd_reg[l];
         case (pd_reg[l])
            FRL_PD_IDLE: begin
               if (ov_flag_reg[l] && ovcfg_reg[l] == FRL_OV_PD)
                  pd_next[l] = FRL_PD_FORCE;
            end
            FRL_PD_FORCE: begin
               if (!ov_flag_reg[l])
                  pd_next[l] = FRL_PD_IDLE;
               else if (det_done[l] || neg_oc[l])
                  pd_next[l] = FRL_PD_SAFE;
            end
            FRL_PD_SAFE: begin
               if (!ov_flag_reg[l])
                  pd_next[l] = FRL_PD_IDLE;
            end
            default: pd_next[l] = FRL_PD_IDLE;
         endcase
      end
   end

   // ************************************
   // reaction outputs
   // ************************************
   // latched faults decide the pins whatever ignored ones say
   wire lat_any = |(flag_reg & react_reg);
   wire pd_safe = pd_reg[0] == FRL_PD_SAFE || pd_reg[1] == FRL_PD_SAFE;
   wire hiz_next = lat_any || ov_lat[0] || ov_lat[1] || pd_safe;
   wire pd0 = ov_flag_reg[0] && ovcfg_reg[0] == FRL_OV_PD;
   wire pd1 = ov_flag_reg[1] && ovcfg_reg[1] == FRL_OV_PD;
   wire [7:0] force_low = ({8{pd0}} & ~PH_L2) | ({8{pd1}} & PH_L2);
   // override ignores the generator's minimum on/off times by design
   wire [7:0] pwm_out_next = hiz_next ? 8'h00 : pwm_in & ~force_low;
   wire [7:0] pwm_oe_next = hiz_next ? 8'h00 : 8'hFF;

   always_comb begin
      for (int l = 0; l < 2; l++) begin
         redir_next[l] = !(|(flag_reg & react_reg & ((l == 0 ? L1_MASK : L2_MASK) | common))
                         || ov_lat[l] || (l == 0 ? pd0 : pd1));
      end
   end

   // ************************************
   // loop enable
   // ************************************
   always_comb begin
      for (int l = 0; l < 2; l++) begin
         req[l] = src_en(src_reg[l], op_reg[l][3:2] != 2'h0,
                         pin_lvl[l] | swen_reg[l]);
      end
   end

   // ************************************
   // tick divider for the start delay
   // ************************************
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tick_cnt_reg <= 13'h0000;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= tick_cnt_reg == 13'(TICK_CYC - 1);
         tick_cnt_reg <= (tick_cnt_reg == 13'(TICK_CYC - 1)) ? 13'h0000
                         : tick_cnt_reg + 13'h0001;
      end
   end

   // configuration written by commands; refused writes keep old value
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         op_reg <= '{default: `FRL_OP_RST};
         src_reg <= '{default: `FRL_SRC_RST};
         ton_reg <= '{default: `FRL_TON_RST};
         ovcfg_reg <= '{default: FRL_OV_PD};
         react_reg <= '1;
         swen_reg <= 2'h0;
         invalid_reg <= 1'b0;
      end else begin
         invalid_reg <= bad_cmd;
         if (is_op && op_ok)
            op_reg[cmd_page] <= cmd_data[`FRL_OP_ON_HI:`FRL_OP_MRG_LO];
         if (is_src && src_ok)
            src_reg[cmd_page] <= src_f;
         if (cmd_wr && cmd_code == FRL_CMD_SWEN)
            swen_reg[cmd_page] <= cmd_data[0];
         if (cmd_wr && cmd_code == FRL_CMD_TON)
            ton_reg[cmd_page] <= cmd_data[8:0];
         if (cmd_wr && cmd_code == FRL_CMD_FHC) begin
            react_reg <= cmd_data[NF-1:0];
            ovcfg_reg[cmd_page] <= frl_ov_e'(cmd_data[`FRL_FHC_OV_HI:`FRL_FHC_OV_LO]);
         end
      end
   end

   // flags, pull-down states and detect delay
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         flag_reg <= '0;
         ov_flag_reg <= 2'h0;
         pd_reg <= '{default: FRL_PD_IDLE};
         det_cnt_reg <= '{default: '0};
      end else begin
         flag_reg <= flag_next;
         ov_flag_reg <= ov_flag_next;
         pd_reg <= pd_next;
         for (int l = 0; l < 2; l++) begin
            if (pd_reg[l] != FRL_PD_FORCE || !vsense_low[l])
               det_cnt_reg[l] <= '0;
            else if (det_cnt_reg[l] != DW'(DET_DLY_CYC))
               det_cnt_reg[l] <= det_cnt_reg[l] + DW'(1);
         end
      end
   end

   // pin side outputs
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hiz_reg <= 1'b0;
         pwm_out_reg <= 8'h00;
         pwm_oe_reg <= 8'h00;
         redir_n_reg <= 2'h3;
      end else begin
         hiz_reg <= hiz_next;
         pwm_out_reg <= pwm_out_next;
         pwm_oe_reg <= pwm_oe_next;
         redir_n_reg <= redir_next;
      end
   end

   // loop enables; reference follows pin edges in pin modes
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ref_state_reg <= 2'h0;
         ctrl_en_reg <= 2'h0;
         ref_en_reg <= 2'h0;
         margin_reg <= 4'h0;
      end else begin
         for (int l = 0; l < 2; l++) begin
            if (pin_rise[l])
               ref_state_reg[l] <= 1'b1;
            else if (pin_fall[l])
               ref_state_reg[l] <= 1'b0;
            ctrl_en_reg[l] <= req[l] && !hiz_reg;
            ref_en_reg[l] <= ton_on[l] && (!pin_mode(src_reg[l])
                             || ref_state_reg[l] || swen_reg[l]);
            margin_reg[2*l +: 2] <= op_reg[l][1:0];
         end
      end
   end

   assign pwm_out = pwm_out_reg;
   assign pwm_oe = pwm_oe_reg;
   assign fault_flag = flag_reg;
   assign ov_flag = ov_flag_reg;
   assign redir_n = redir_n_reg;
   assign loop_ctrl_en = ctrl_en_reg;
   assign ref_en = ref_en_reg;
   assign margin = margin_reg;
   assign invalid_cmd = invalid_reg;

   // ************************************
   // checks
   // ************************************
   // both pages side by side: one command a cycle, so neither may move
   wire [7:0] op_both = {op_reg[1], op_reg[0]};

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence s_force_then_noc;
      pd_reg[0] == FRL_PD_FORCE && ov_flag_reg[0] ##0 neg_oc[0];
   endsequence

   a_latch_hiz: assert property (lat_any |=> pwm_oe == 8'h00)
      else $error("latched fault left pins driven");
   a_redir_common: assert property (|(flag_reg & react_reg & common) |=> redir_n == 2'h0)
      else $error("common latched fault not redirected");
   a_flag_persist: assert property (
      ##1 (fault_flag & $past(fault_det)) == $past(fault_det))
      else $error("flag lost while fault present");
   a_pd_safe_step: assert property (
      s_force_then_noc |=> pd_reg[0] == FRL_PD_SAFE ##1 hiz_reg)
      else $error("pull-down did not reach safe state");
   a_pd_low: assert property (pd0 && !hiz_next |=> (pwm_out & ~PH_L2) == 8'h00)
      else $error("loop 1 pins not forced low");
   a_src_always: assert property (
      src_reg[0][2] == 1'b0 && !hiz_reg |=> loop_ctrl_en[0])
      else $error("source 0xx did not enable loop");
   a_op_off: assert property (
      src_reg[0] == 3'h6 && op_reg[0][3:2] == 2'h0 |=> !loop_ctrl_en[0])
      else $error("operation off did not disable loop");
   a_bad_op: assert property (
      is_op && !op_ok |=> invalid_cmd && op_both == $past(op_both))
      else $error("invalid operation stored");
   a_ign_quiet: assert property (
      !hiz_next && !pd0 && !pd1 |=> pwm_oe == 8'hFF && pwm_out == $past(pwm_in))
      else $error("ignored fault changed pins");
endmodule

// ===== rtl/frl_turn_on_delay_count.sv
// turn-on delay counter stepped by the shared tick
`include "frl_defines.svh"
module frl_turn_on_delay_count (
   input wire logic clock, // system clock
   input wire logic rstn, // async reset, active low
   input wire logic tick, // one pulse per tick period
   input wire logic req, // loop start request level
   input wire logic [8:0] dly, // delay in milliseconds
   output logic on // delayed start, level
);
   logic [13:0] cnt_reg;
   logic on_reg;
   // whole milliseconds as a count of ticks
   wire [13:0] target = 14'(dly) * 14'(`FRL_TICKS_PER_MS);

   // the first tick may come at once, hence one tick of jitter
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= 14'h0000;
         on_reg <= 1'b0;
      end else if (!req) begin
         cnt_reg <= 14'h0000;
         on_reg <= 1'b0;
      end else if (!on_reg) begin
         if (dly == 9'h000)
            on_reg <= 1'b1;
         else if (tick && cnt_reg == target - 14'h0001)
            on_reg <= 1'b1;
         else if (tick)
            cnt_reg <= cnt_reg + 14'h0001;
      end
   end

   assign on = on_reg;

   a_ton_zero: assert property (@(posedge clock) disable iff (!rstn)
      req && dly == 9'h000 |=> on || !req) else $error("zero delay not immediate");
   a_ton_drop: assert property (@(posedge clock) disable iff (!rstn)
      !req |=> !on) else $error("start held without request");
endmodule

// ===== verif/frl_host.sv
// host model driving the two loop enable pins
module frl_host #(
   parameter int LOW_CYC = 2100 // low time, above the clear minimum
) (
   input wire logic clock, // system clock
   input wire logic [1:0] go, // pins to pulse low
   output logic [1:0] pin // loop enable pins
);
   timeunit 1ns;
   timeprecision 1ps;
   int n;
   // pins start low, never tied high: first pulse gives a clean rise
   initial begin
      pin = 2'b00;
      n = 0;
   end
   always @(negedge clock) begin
      if (go != 2'b00 && n == 0) begin
         pin <= pin & ~go;
         n <= LOW_CYC;
      end else if (n > 1) begin
         n <= n - 1;
      end else if (n == 1) begin
         pin <= 2'b11;
         n <= 0;
      end
   end
endmodule

// ===== verif/frl_top_tb.sv
// self-checking bench for the fault reaction and loop enable block
module frl_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import frl_pkg::*;
   logic clock, rstn, cmd_wr, cmd_page, inv_seen, invalid_cmd;
   logic [1:0] go, pin, ov_det, neg_oc, ov_flag, redir_n, loop_ctrl_en, ref_en, vs_low;
   logic [7:0] fault_det, pwm_out, pwm_oe, fault_flag;
   logic [3:0] margin;
   logic [15:0] cmd_data;
   frl_cmd_e cmd_code;
   int mismatches, checks_done;
   // short tick keeps delay runs brief
   frl_top #(.TICK_CYC(4)) i_frl_top (.clock(clock), .rstn(rstn), .loop_enable_pin(pin),
      .pwm_in(8'hFF), .fault_det(fault_det), .ov_det(ov_det), .vsense_low(vs_low),
      .neg_oc(neg_oc), .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_page(cmd_page),
      .cmd_data(cmd_data), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .fault_flag(fault_flag),
      .ov_flag(ov_flag), .redir_n(redir_n), .loop_ctrl_en(loop_ctrl_en), .ref_en(ref_en),
      .margin(margin), .invalid_cmd(invalid_cmd));
   frl_host i_frl_host (.clock(clock), .go(go), .pin(pin));
   // ************************************
   // tasks
   // ************************************
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clock);
   endtask
   // strobe held for exactly one sampling edge
   task automatic cmd(input frl_cmd_e c, input logic p, input logic [15:0] d);
      @(negedge clock);
      cmd_wr = 1'b1;
      cmd_code = c;
      cmd_page = p;
      cmd_data = d;
      wt(1);
      cmd_wr = 1'b0;
      wt(4);
   endtask
   task automatic pin_clr(input logic [1:0] m);
      @(negedge clock);
      go <= m;
      wt(1);
      go <= 2'b00;
      wt(2130);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // refusal pulse lasts one cycle, so catch it
   always @(posedge clock) if (invalid_cmd === 1'b1) inv_seen <= 1'b1;
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // whole run is about 7000 cycles
   initial begin
      #200000;
      mismatches++;
      end_of_test;
   end
   initial begin
      {rstn, cmd_wr, cmd_page, inv_seen, go, ov_det, neg_oc, vs_low, fault_det} = '0;
      cmd_code = FRL_CMD_NONE;
      cmd_data = 16'h0000;
      wt(3);
      rstn = 1'b1;
      wt(3);
      chk("oe", 16'h00FF, pwm_oe);
      chk("redir", 16'h0003, redir_n);
      chk("ref", 16'h0000, ref_en);
      pin_clr(2'b11);
      chk("ref", 16'h0003, ref_en);
      chk("ctrl", 16'h0003, loop_ctrl_en);
      fault_det = 8'h14;
      wt(4);
      chk("flag", 16'h0014, fault_flag);
      chk("oe", 16'h0000, pwm_oe);
      chk("redir", 16'h0000, redir_n);
      cmd(FRL_CMD_CLR_ALL, 1'b1, 16'h0000);
      chk("flag", 16'h0014, fault_flag);
      fault_det = 8'h00;
      cmd(FRL_CMD_CLR_ALL, 1'b0, 16'h0000);
      chk("flag", 16'h0004, fault_flag);
      cmd(FRL_CMD_CLR_ALL, 1'b1, 16'h0000);
      chk("flag", 16'h0000, fault_flag);
      chk("oe", 16'h00FF, pwm_oe);
      $display("test latched done");
      cmd(FRL_CMD_FHC, 1'b0, 16'hC0EF);
      fault_det = 8'h10;
      wt(4);
      chk("flag", 16'h0010, fault_flag);
      chk("oe", 16'h00FF, pwm_oe);
      fault_det = 8'h11;
      wt(4);
      chk("oe", 16'h0000, pwm_oe);
      fault_det = 8'h00;
      cmd(FRL_CMD_CLR_ALL, 1'b0, 16'h0000);
      chk("flag", 16'h0000, fault_flag);
      $display("test ignore done");
      cmd(FRL_CMD_TON, 1'b1, 16'h0002);
      fault_det = 8'h01;
      wt(4);
      fault_det = 8'h00;
      pin_clr(2'b10);
      chk("flag", 16'h0001, fault_flag);
      pin_clr(2'b01);
      chk("flag", 16'h0000, fault_flag);
      // loop 2 waits 2 ms, 64 ticks of 4 cycles, loop 1 starts at once
      chk("ref", 16'h0001, ref_en);
      wt(270);
      chk("ref", 16'h0003, ref_en);
      $display("test pin clear done");
      ov_det = 2'b01;
      wt(4);
      chk("ovflag", 16'h0001, ov_flag);
      chk("pwm", 16'h0000, pwm_out[3:0]);
      chk("oe", 16'h00FF, pwm_oe);
      neg_oc = 2'b01;
      wt(4);
      chk("oe", 16'h0000, pwm_oe);
      {ov_det, neg_oc} = 4'h0;
      cmd(FRL_CMD_CLR_ONE, 1'b0, 16'h0008);
      chk("ovflag", 16'h0000, ov_flag);
      // loop 2 pull-down ends on low sense after the detect delay
      ov_det = 2'b10;
      vs_low = 2'b10;
      wt(4);
      chk("pwm", 16'h0000, pwm_out[7:4]);
      chk("oe", 16'h00FF, pwm_oe);
      wt(20);
      chk("oe", 16'h0000, pwm_oe);
      {ov_det, vs_low} = 4'h0;
      cmd(FRL_CMD_CLR_ALL, 1'b1, 16'h0000);
      chk("ovflag", 16'h0000, ov_flag);
      $display("test pull-down done");
      cmd(FRL_CMD_OP, 1'b0, 16'h0090);
      chk("margin", 16'h0001, margin[1:0]);
      cmd(FRL_CMD_OP, 1'b0, 16'h00A0);
      chk("margin", 16'h0002, margin[1:0]);
      cmd(FRL_CMD_OP, 1'b0, 16'h0040);
      chk("inv", 16'h0001, inv_seen);
      inv_seen = 1'b0;
      cmd(FRL_CMD_SRC, 1'b0, 16'h0010);
      chk("inv", 16'h0001, inv_seen);
      cmd(FRL_CMD_SRC, 1'b0, 16'h0000);
      chk("ctrl", 16'h0001, loop_ctrl_en[0]);
      cmd(FRL_CMD_SRC, 1'b0, 16'h0018);
      cmd(FRL_CMD_OP, 1'b0, 16'h0000);
      chk("ctrl", 16'h0000, loop_ctrl_en[0]);
      $display("test commands done");
      end_of_test;
   end
endmodule
